// >>> icd_hold_timer.sv
// Purpose: qualifies a level that must stay high a minimum time
// Assumes: level_in is already synchronous to ref_clk
// Notes:   held goes high after HOLD_CYC consecutive high cycles
`default_nettype none
`timescale 1ns/1ps
module icd_hold_timer #(
    parameter int HOLD_CYC = 200000
) (
    input  wire logic ref_clk,  // system clock
    input  wire logic reset,    // async, active high
    input  wire logic level_in, // level to qualify
    output logic      held      // level held long enough
);
    localparam int CW = $clog2(HOLD_CYC + 1);
    logic [CW-1:0] cnt_ff;

    initial begin
        if (HOLD_CYC < 1) $error("icd_hold_timer: HOLD_CYC below one");
    end

    // counter saturates so a long press never wraps back to idle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
            held   <= 1'b0;
        end else if (!level_in) begin
            cnt_ff <= '0;
            held   <= 1'b0;
        end else if (cnt_ff != CW'(HOLD_CYC)) begin
            cnt_ff <= cnt_ff + CW'(1);
            held   <= (cnt_ff == CW'(HOLD_CYC - 1));
        end
    end
endmodule // icd_hold_timer
`default_nettype wire

// >>> icd_pkg.sv
// Purpose: constants and carriers for the input terminal command decoder
// Assumes: one 20 MHz clock, terminal level 1 = terminal shorted to common
// Notes:   codes at or above the negative-logic offset invert the terminal
`default_nettype none
package icd_pkg;
    // -------------------------------------------------------------
    // terminal layout and code encoding
    // -------------------------------------------------------------
    localparam int          NUM_TERM    = 5;
    localparam int          TERM_FWD    = 3;     // dedicated run terminal
    localparam int          TERM_REV    = 4;     // dedicated run terminal
    localparam int          CODE_W      = 11;
    localparam logic [10:0] NEG_OFFSET  = 11'h3E8;  // 1000: negative logic
    localparam logic [10:0] CODE_SPD_B0 = 11'h000;  // speed select weight 1
    localparam logic [10:0] CODE_SPD_B1 = 11'h001;  // weight 2
    localparam logic [10:0] CODE_SPD_B2 = 11'h002;  // weight 4
    localparam logic [10:0] CODE_RAMP   = 11'h004;
    localparam logic [10:0] CODE_HOLD3W = 11'h006;
    localparam logic [10:0] CODE_COAST  = 11'h007;
    localparam logic [10:0] CODE_FCLR   = 11'h008;
    localparam logic [10:0] CODE_EXTF   = 11'h009;
    localparam logic [10:0] CODE_INCH   = 11'h00A;
    localparam logic [10:0] CODE_FSRC   = 11'h00B;
    localparam logic [10:0] CODE_EDIT   = 11'h013;
    localparam logic [10:0] CODE_LOOP   = 11'h014;
    localparam logic [10:0] CODE_INV    = 11'h015;
    localparam logic [10:0] CODE_LINK   = 11'h018;
    localparam logic [10:0] CODE_LCLR   = 11'h021;
    localparam logic [10:0] CODE_IHOLD  = 11'h022;
    localparam logic [10:0] CODE_FWD    = 11'h062;
    localparam logic [10:0] CODE_REV    = 11'h063;
    localparam logic [1:0]  RUN_SRC_TERMINAL = 2'h1;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_HZ         = 20_000_000;
    localparam int FAULT_CLEAR_MS = 10;
    localparam int FAULT_CLEAR_CYC = FAULT_CLEAR_MS * (CLK_HZ / 1000);
    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [10:0] code_multi_1;
        logic [10:0] code_multi_2;
        logic [10:0] code_multi_3;
        logic [10:0] code_fwd;
        logic [10:0] code_rev;
    } icd_cfg_type;

    typedef struct packed {
        logic [2:0] speed_index;      // 0 = normal source, 1..7 presets
        logic       ramp_set_select;  // second accel/decel pair
        logic       forward_run;
        logic       backward_run;
        logic       drive_enable;     // low = output cut, motor coasts
        logic       coast_stop;
        logic       ext_alarm;        // sticky external equipment alarm
        logic       alarm_clear;      // alarm outputs cleared
        logic       alarm_resume;     // one-cycle pulse on fault-clear release
        logic       jog_ready;
        logic       jog_run;
        logic       freq_source_select;
        logic       edit_all;
        logic       edit_self_only;
        logic       loop_control_enable;
        logic       manual_invert;
        logic       loop_action_inverse;
        logic       link_operation_select;
        logic       loop_terms_clear;
        logic       integral_hold;
    } icd_cmd_type;
endpackage : icd_pkg
`default_nettype wire

// >>> icd_switch_model.sv
// Purpose: external switch bank that drives the five input terminals
// Assumes: contacts do not bounce; 1 = terminal shorted to common
// Notes:   changes land on ref_clk edges so the run repeats exactly
`default_nettype none
`timescale 1ns/1ps
module icd_switch_model (
    input  wire logic       ref_clk,  // system clock
    input  wire logic [4:0] sw_req,   // requested closures
    output logic      [4:0] term_pin  // terminal levels
);
    // closure follows the request one edge later; the bench keeps the
    // fault clear contact closed past its minimum time when it means it
    always_ff @(posedge ref_clk) begin
        term_pin <= sw_req;
    end
endmodule // icd_switch_model
`default_nettype wire

// >>> icd_sync.sv
// Purpose: three-stage synchroniser for terminal levels
// Assumes: input changes asynchronously to ref_clk
// Notes:   output follows once stages two and three agree
`default_nettype none
`timescale 1ns/1ps
module icd_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             ref_clk,  // system clock
    input  wire logic             reset,    // async, active high
    input  wire logic [WIDTH-1:0] pin_in,   // raw terminal levels
    output logic      [WIDTH-1:0] level_out // filtered levels
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    initial begin
        if (WIDTH < 1) $error("icd_sync: WIDTH must be positive");
    end

    // s1 feeds only s2, to keep metastability away from logic
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // per bit: accept a change only when two stages agree
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_ff[i] == s3_ff[i]) level_out[i] <= s3_ff[i];
            end
        end
    end
endmodule // icd_sync
`default_nettype wire

// >>> icd_tb.sv
// Purpose: self-checking bench for the terminal command decoder
// Assumes: fault clear hold shortened to FCC cycles
// Notes:   every scenario waits out the five-edge terminal latency
`default_nettype none
`timescale 1ns/1ps
module tb;
    localparam int          FCC  = 8;
    localparam logic [10:0] NONE = 11'h7FF; // negative base, no command
    logic                 ref_clk;
    logic                 reset;
    logic [4:0]           sw;
    logic [4:0]           term_pin;
    icd_pkg::icd_cfg_type cfg;
    logic [1:0]           rsrc;
    logic                 prot, act, alm, mrun, kp, rkey;
    icd_pkg::icd_cmd_type cmd;
    int                   errors, check_count, cycles;
    // -------------------------------------------------------------
    // instances
    // -------------------------------------------------------------
    icd_switch_model icd_switch_model_i (.ref_clk(ref_clk), .sw_req(sw),
        .term_pin(term_pin));
    icd_top #(.FAULT_CLEAR_CYC(FCC)) icd_top_i (.ref_clk(ref_clk),
        .reset(reset), .term_pin(term_pin), .cfg(cfg),
        .run_source_setting(rsrc), .edit_protect_setting(prot),
        .loop_action_setting(act), .alarm_mode(alm),
        .motor_running(mrun), .jog_key_pair(kp), .run_key(rkey),
        .cmd_ff(cmd));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // #1 lets the edge's register updates land before sampling
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic put(input logic [4:0] p);
        @(posedge ref_clk);
        sw <= p;
        settle(7);
    endtask
    task automatic cfgset(input logic [10:0] a, b, c, d, e);
        @(posedge ref_clk);
        cfg <= '{a, b, c, d, e};
        sw  <= 5'h00;
        settle(7);
    endtask
    task automatic pulse_key();
        @(posedge ref_clk);
        kp <= 1'b1;
        @(posedge ref_clk);
        kp <= 1'b0;
        settle(3);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = cmd.ramp_set_select;
            1: pick = cmd.coast_stop;
            2: pick = cmd.freq_source_select;
            3: pick = cmd.loop_control_enable;
            4: pick = cmd.link_operation_select;
            5: pick = cmd.loop_terms_clear;
            default: pick = cmd.integral_hold;
        endcase
    endfunction
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_speed();
        cfgset(icd_pkg::CODE_SPD_B0, icd_pkg::CODE_SPD_B1,
               icd_pkg::CODE_SPD_B2, NONE, NONE);
        for (int i = 0; i < 8; i++) begin
            put(i[4:0]);
            chk("speed_index", {5'h00, cmd.speed_index}, i[7:0]);
        end
        cfgset(icd_pkg::CODE_SPD_B0 + icd_pkg::NEG_OFFSET, NONE, NONE,
               NONE, NONE);
        chk("neg_open", {5'h00, cmd.speed_index}, 8'h01);
        put(5'h01);
        chk("neg_closed", {5'h00, cmd.speed_index}, 8'h00);
    endtask
    task automatic t_levels();
        logic [10:0] codes [7];
        codes = '{icd_pkg::CODE_RAMP, icd_pkg::CODE_COAST,
                  icd_pkg::CODE_FSRC, icd_pkg::CODE_LOOP,
                  icd_pkg::CODE_LINK, icd_pkg::CODE_LCLR,
                  icd_pkg::CODE_IHOLD};
        cfgset(NONE, NONE, NONE, NONE, NONE);
        chk("link_unassigned", {7'h00, cmd.link_operation_select}, 8'h01);
        chk("edit_unassigned", {7'h00, cmd.edit_all}, 8'h01);
        for (int k = 0; k < 7; k++) begin
            cfgset(NONE, codes[k], NONE, NONE, NONE);
            put(5'h02);
            chk("level_on", {7'h00, pick(k)}, 8'h01);
            if (k == 1)
                chk("drive_enable", {7'h00, cmd.drive_enable}, 8'h00);
            put(5'h00);
            chk("level_off", {7'h00, pick(k)}, 8'h00);
            if (k == 1)
                chk("drive_on", {7'h00, cmd.drive_enable}, 8'h01);
        end
    endtask
    task automatic t_edit();
        cfgset(icd_pkg::CODE_EDIT, NONE, NONE, NONE, NONE);
        chk("edit_off", {6'h00, cmd.edit_all, cmd.edit_self_only}, 8'h00);
        put(5'h01);
        chk("edit_all", {6'h00, cmd.edit_all, cmd.edit_self_only}, 8'h02);
        @(posedge ref_clk);
        prot <= 1'b1;
        settle(3);
        chk("edit_self", {6'h00, cmd.edit_all, cmd.edit_self_only}, 8'h01);
        @(posedge ref_clk);
        prot <= 1'b0;
    endtask
    task automatic t_run();
        cfgset(icd_pkg::CODE_FWD, NONE, icd_pkg::CODE_HOLD3W,
               icd_pkg::CODE_FWD, icd_pkg::CODE_REV);
        put(5'h01);
        chk("fwd_on_x1", {7'h00, cmd.forward_run}, 8'h00);
        put(5'h08);
        chk("fwd", {6'h00, cmd.forward_run, cmd.backward_run}, 8'h02);
        put(5'h18);
        chk("both", {6'h00, cmd.forward_run, cmd.backward_run}, 8'h00);
        put(5'h10);
        chk("rev", {6'h00, cmd.forward_run, cmd.backward_run}, 8'h01);
        put(5'h04);
        chk("rev_off", {7'h00, cmd.backward_run}, 8'h00);
        put(5'h0C);
        put(5'h04);
        chk("held_fwd", {7'h00, cmd.forward_run}, 8'h01);
        put(5'h00);
        chk("hold_drop", {7'h00, cmd.forward_run}, 8'h00);
    endtask
    task automatic t_alarm();
        cfgset(icd_pkg::CODE_FCLR, icd_pkg::CODE_EXTF, NONE, NONE, NONE);
        chk("no_trip_idle", {6'h00, cmd.ext_alarm, cmd.drive_enable}, 8'h01);
        put(5'h02);
        @(posedge ref_clk);
        mrun <= 1'b1;
        put(5'h00);
        chk("ext_alarm", {6'h00, cmd.ext_alarm, cmd.drive_enable}, 8'h02);
        @(posedge ref_clk);
        alm  <= 1'b1;
        mrun <= 1'b0;
        sw   <= 5'h03;
        repeat (3) @(posedge ref_clk);
        sw <= 5'h02;
        settle(12);
        chk("short_clear", {6'h00, cmd.ext_alarm, cmd.alarm_clear}, 8'h02);
        @(posedge ref_clk);
        sw <= 5'h03;
        settle(FCC + 10);
        chk("alarm_clear", {7'h00, cmd.alarm_clear}, 8'h01);
        @(posedge ref_clk);
        sw <= 5'h02;
        settle(6);
        chk("resume_pulse", {5'h00, cmd.alarm_resume, cmd.ext_alarm,
            cmd.alarm_clear}, 8'h04);
        settle(1);
        chk("resumed", {5'h00, cmd.alarm_resume, cmd.ext_alarm,
            cmd.alarm_clear}, 8'h00);
        @(posedge ref_clk);
        alm <= 1'b0;
    endtask
    task automatic t_jog();
        cfgset(icd_pkg::CODE_INCH, icd_pkg::CODE_INV, icd_pkg::CODE_LOOP,
               NONE, NONE);
        put(5'h01);
        chk("jog_ready", {7'h00, cmd.jog_ready}, 8'h01);
        @(posedge ref_clk);
        rkey <= 1'b1;
        settle(3);
        chk("jog_run", {7'h00, cmd.jog_run}, 8'h01);
        @(posedge ref_clk);
        rkey <= 1'b0;
        pulse_key();
        put(5'h00);
        chk("inch_key_ignored", {7'h00, cmd.jog_ready}, 8'h00);
        pulse_key();
        chk("key_toggle", {7'h00, cmd.jog_ready}, 8'h01);
        pulse_key();
        chk("key_toggle2", {7'h00, cmd.jog_ready}, 8'h00);
        @(posedge ref_clk);
        rsrc <= icd_pkg::RUN_SRC_TERMINAL;
        pulse_key();
        chk("key_terminal", {7'h00, cmd.jog_ready}, 8'h00);
        @(posedge ref_clk);
        rsrc <= 2'h0;
        put(5'h02);
        chk("manual_inv", {7'h00, cmd.manual_invert}, 8'h01);
        put(5'h06);
        chk("loop_inv", {7'h00, cmd.loop_action_inverse}, 8'h01);
        @(posedge ref_clk);
        act <= 1'b1;
        settle(3);
        chk("loop_inv_swap", {7'h00, cmd.loop_action_inverse}, 8'h00);
    endtask
    // -------------------------------------------------------------
    // clock, run, timeout and verdict
    // -------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // free-running clock, 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // a hang costs a mismatch rather than a silent stall
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    // main sequence
    initial begin
        {errors, check_count, cycles} = '0;
        reset = 1'b1;
        sw = 5'h00;
        cfg = '{NONE, NONE, NONE, NONE, NONE};
        {rsrc, prot, act, alm, mrun, kp, rkey} = '0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        settle(4);
        t_speed();
        t_levels();
        t_edit();
        t_run();
        t_alarm();
        t_jog();
        end_of_test();
    end
endmodule // tb
`default_nettype wire

// >>> icd_top.sv
// Purpose: decodes five programmable input terminals into drive commands
// Assumes: term_pin bit set = terminal shorted to common; others same clock
// Notes:   all outputs registered; pin to output latency is five edges
`default_nettype none
`timescale 1ns/1ps
module icd_top #(
    parameter int FAULT_CLEAR_CYC = icd_pkg::FAULT_CLEAR_CYC
) (
    input  wire logic                ref_clk,        // 20 MHz clock
    input  wire logic                reset,          // async, active high
    input  wire logic [4:0]          term_pin,       // multi 1..3, fwd, rev
    input  wire icd_pkg::icd_cfg_type cfg,           // terminal codes
    input  wire logic [1:0]          run_source_setting, // 1 = terminals
    input  wire logic                edit_protect_setting, // 0 all, 1 self
    input  wire logic                loop_action_setting,  // 1 = inverse
    input  wire logic                alarm_mode,     // drive in alarm mode
    input  wire logic                motor_running,  // motor is turning
    input  wire logic                jog_key_pair,   // key pair pulse
    input  wire logic                run_key,        // keypad run key level
    output icd_pkg::icd_cmd_type     cmd_ff          // decoded commands
);
    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    initial begin
        if (FAULT_CLEAR_CYC < 1) $error("icd_top: FAULT_CLEAR_CYC < 1");
    end

    // ---------------------------------------------------------------
    // terminal capture
    // ---------------------------------------------------------------
    logic [4:0]  term_lvl;
    logic [10:0] code_arr [5];

    icd_sync #(.WIDTH(icd_pkg::NUM_TERM)) u_sync (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .pin_in    (term_pin),
        .level_out (term_lvl)
    );

    // order matches term_pin bit positions
    assign code_arr[0] = cfg.code_multi_1;
    assign code_arr[1] = cfg.code_multi_2;
    assign code_arr[2] = cfg.code_multi_3;
    assign code_arr[3] = cfg.code_fwd;
    assign code_arr[4] = cfg.code_rev;

    // strip the negative-logic offset from a code
    function automatic logic [10:0] base_code(input logic [10:0] c);
        base_code = (c >= icd_pkg::NEG_OFFSET) ? c - icd_pkg::NEG_OFFSET : c;
    endfunction

    // true when terminal t carries command c (run codes only on run pins)
    function automatic logic maps(input int t, input logic [10:0] c);
        logic run_code;
        run_code = (c == icd_pkg::CODE_FWD) || (c == icd_pkg::CODE_REV);
        maps = (base_code(code_arr[t]) == c) &&
               (!run_code || t == icd_pkg::TERM_FWD ||
                t == icd_pkg::TERM_REV);
    endfunction

    // command asserted by any terminal carrying it
    function automatic logic cmd_on(input logic [10:0] c);
        logic neg;
        cmd_on = 1'b0;
        for (int t = 0; t < icd_pkg::NUM_TERM; t++) begin
            neg = code_arr[t] >= icd_pkg::NEG_OFFSET;
            if (maps(t, c) && (term_lvl[t] ^ neg)) cmd_on = 1'b1;
        end
    endfunction

    // command carried by any terminal at all
    function automatic logic assigned(input logic [10:0] c);
        assigned = 1'b0;
        for (int t = 0; t < icd_pkg::NUM_TERM; t++) begin
            if (maps(t, c)) assigned = 1'b1;
        end
    endfunction

    // ---------------------------------------------------------------
    // decoded command levels
    // ---------------------------------------------------------------
    logic [2:0] spd_idx;
    logic fwd_in, rev_in, hold3w, coast, fclr, inch, fsrc;
    logic edit_on, loop_on, inv_on, link_on, extf_open;

    // a process, not assigns: the functions read codes and levels that
    // are not their arguments, and an assign would only wake on those
    always_comb begin
        spd_idx   = {cmd_on(icd_pkg::CODE_SPD_B2),
                     cmd_on(icd_pkg::CODE_SPD_B1),
                     cmd_on(icd_pkg::CODE_SPD_B0)};
        fwd_in    = cmd_on(icd_pkg::CODE_FWD);
        rev_in    = cmd_on(icd_pkg::CODE_REV);
        hold3w    = cmd_on(icd_pkg::CODE_HOLD3W);
        coast     = cmd_on(icd_pkg::CODE_COAST);
        fclr      = cmd_on(icd_pkg::CODE_FCLR);
        inch      = cmd_on(icd_pkg::CODE_INCH);
        fsrc      = cmd_on(icd_pkg::CODE_FSRC);
        edit_on   = cmd_on(icd_pkg::CODE_EDIT) ||
                    !assigned(icd_pkg::CODE_EDIT);
        loop_on   = cmd_on(icd_pkg::CODE_LOOP);
        inv_on    = cmd_on(icd_pkg::CODE_INV);
        link_on   = cmd_on(icd_pkg::CODE_LINK) ||
                    !assigned(icd_pkg::CODE_LINK);
        // an unassigned fault input can never open
        extf_open = assigned(icd_pkg::CODE_EXTF) &&
                    !cmd_on(icd_pkg::CODE_EXTF);
    end

    // ---------------------------------------------------------------
    // three-wire self hold
    // ---------------------------------------------------------------
    logic fwd_lat_ff;
    logic rev_lat_ff;
    logic nxt_fwd;
    logic nxt_rev;

    // latch a momentary press; the other direction's press takes over
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fwd_lat_ff <= 1'b0;
            rev_lat_ff <= 1'b0;
        end else if (!hold3w) begin
            fwd_lat_ff <= 1'b0;
            rev_lat_ff <= 1'b0;
        end else if (fwd_in ^ rev_in) begin
            fwd_lat_ff <= fwd_in;
            rev_lat_ff <= rev_in;
        end
    end

    // both at once is a stop, never a direction pick
    always_comb begin
        nxt_fwd = fwd_in || (hold3w && fwd_lat_ff);
        nxt_rev = rev_in || (hold3w && rev_lat_ff);
        if (nxt_fwd && nxt_rev) begin
            nxt_fwd = 1'b0;
            nxt_rev = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // fault clear and external alarm
    // ---------------------------------------------------------------
    logic fclr_held;
    logic clr_seen_ff;

    icd_hold_timer #(.HOLD_CYC(FAULT_CLEAR_CYC)) u_fclr (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level_in (fclr),
        .held     (fclr_held)
    );

    // remembers a qualified clear so its release can trigger resume
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clr_seen_ff <= 1'b0;
        // fclr in the set term keeps the resume pulse to one cycle
        end else if (fclr_held && fclr && alarm_mode) begin
            clr_seen_ff <= 1'b1;
        end else if (!fclr) begin
            clr_seen_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // keypad jog readiness toggle
    // ---------------------------------------------------------------
    logic jog_tog_ff;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            jog_tog_ff <= 1'b0;
        end else if (jog_key_pair && !inch &&
                     run_source_setting != icd_pkg::RUN_SRC_TERMINAL) begin
            jog_tog_ff <= !jog_tog_ff;
        end
    end

    // ---------------------------------------------------------------
    // output register
    // ---------------------------------------------------------------
    logic nxt_trip;
    logic resume;

    assign resume   = clr_seen_ff && !fclr;
    // a new trip wins over a resume in the same cycle
    assign nxt_trip = (extf_open && motor_running) ||
                      (cmd_ff.ext_alarm && !resume);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_ff <= '0;
        end else begin
            cmd_ff.speed_index        <= spd_idx;
            cmd_ff.ramp_set_select    <= cmd_on(icd_pkg::CODE_RAMP);
            cmd_ff.forward_run        <= nxt_fwd;
            cmd_ff.backward_run       <= nxt_rev;
            cmd_ff.coast_stop         <= coast;
            cmd_ff.drive_enable       <= !coast && !nxt_trip;
            cmd_ff.ext_alarm          <= nxt_trip;
            cmd_ff.alarm_clear        <= fclr_held && fclr &&
                                         alarm_mode;
            cmd_ff.alarm_resume       <= resume;
            cmd_ff.jog_ready          <= inch || jog_tog_ff;
            cmd_ff.jog_run            <= (inch || jog_tog_ff) &&
                                         (nxt_fwd || nxt_rev || run_key);
            cmd_ff.freq_source_select <= fsrc;
            cmd_ff.edit_all           <= edit_on &&
                                         !edit_protect_setting;
            cmd_ff.edit_self_only     <= edit_on &&
                                         edit_protect_setting;
            cmd_ff.loop_control_enable <= loop_on;
            cmd_ff.manual_invert      <= inv_on && !loop_on;
            cmd_ff.loop_action_inverse <= loop_on &&
                                   (loop_action_setting ^ inv_on);
            cmd_ff.link_operation_select <= link_on;
            cmd_ff.loop_terms_clear   <= cmd_on(icd_pkg::CODE_LCLR);
            cmd_ff.integral_hold      <= cmd_on(icd_pkg::CODE_IHOLD);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_both_run;
        fwd_in && rev_in && !hold3w;
    endsequence

    sequence s_coast_seen;
        coast ##1 1'b1;
    endsequence

    no_dual_run_a: assert property (s_both_run |=>
        !cmd_ff.forward_run && !cmd_ff.backward_run)
        else $error("both run directions driven");

    coast_cuts_a: assert property (s_coast_seen |->
        !cmd_ff.drive_enable && !cmd_ff.ext_alarm ||
        $past(nxt_trip))
        else $error("coast did not cut output");

    speed_index_a: assert property (1'b1 |=>
        cmd_ff.speed_index == $past(spd_idx))
        else $error("speed index mismatch");

    trip_latch_a: assert property (extf_open && motor_running |=>
        cmd_ff.ext_alarm && !cmd_ff.drive_enable)
        else $error("external fault not tripped");

    trip_sticky_a: assert property (cmd_ff.ext_alarm && !resume |=>
        cmd_ff.ext_alarm)
        else $error("external alarm dropped without resume");

    clear_needs_alarm_a: assert property (cmd_ff.alarm_clear |->
        $past(alarm_mode) && $past(fclr))
        else $error("alarm clear without qualified input");

    hold_release_a: assert property (!hold3w |=>
        !fwd_lat_ff && !rev_lat_ff)
        else $error("three-wire latch not released");

    edit_block_a: assert property (!edit_on |=>
        !cmd_ff.edit_all && !cmd_ff.edit_self_only)
        else $error("edit allowed while permit off");

    link_default_a: assert property (!assigned(icd_pkg::CODE_LINK) |=>
        cmd_ff.link_operation_select)
        else $error("unassigned link select not on");

    jog_toggle_a: assert property (jog_key_pair && inch |=>
        $stable(jog_tog_ff))
        else $error("jog toggle accepted with inch input on");
endmodule // icd_top
`default_nettype wire
